// [ssp_pkg.sv]
// shared constants and types for the sensor streaming port
`default_nettype none
package ssp_pkg;
   // core clock and link bit timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int LINK_PERIOD_NS = 125;
   // quarter of a link bit, least time, rounded up to whole core cycles
   localparam int QTR_CYC = (LINK_PERIOD_NS * 1000 / 4 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int QCNT_W = $clog2(QTR_CYC + 1);
   // two-wire control byte
   localparam logic [6:0] DEV_ADDR = 7'h44;
   localparam logic WR_BIT = 1'b0;
   // bits per byte on each link, one-wire adds a start and a stop bit
   localparam logic [3:0] I2C_BITS = 4'h8;
   localparam logic [3:0] OW_BITS = 4'hA;
   // tuning
   localparam int CNT_W = 16;
   localparam int MULT_W = 4;
   localparam int COMP_W = 6;
   localparam logic [CNT_W-1:0] TARGET_DEF = 16'h0400;
   localparam logic [CNT_W-1:0] TARGET_ALT = 16'h0200;
   localparam int TOL_SHIFT = 5;
   localparam int RANGE_SHIFT = 2;
   localparam logic [MULT_W-1:0] MULT_RST = 4'h0;
   localparam logic [COMP_W-1:0] COMP_RST = 6'h20;
   // frame: status, count high, count low, compensation
   localparam int FRAME_BYTES = 4;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } ssp_byte_type;

   typedef struct packed {
      logic done;
      logic [CNT_W-1:0] count;
   } ssp_meas_type;

   typedef struct packed {
      logic [MULT_W-1:0] mult;
      logic [COMP_W-1:0] comp;
   } ssp_tune_type;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_START = 3'h1,
      TX_BITS = 3'h3,
      TX_ACK = 3'h2,
      TX_STOP = 3'h6,
      TX_FLUSH = 3'h7
   } ssp_tx_state_type;

   typedef enum logic {
      ATI_RUN = 1'b0,
      ATI_TUNE = 1'b1
   } ssp_ati_state_type;

   function automatic logic [CNT_W-1:0] ssp_absdiff(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
      return (a >= b) ? a - b : b - a;
   endfunction
endpackage
`default_nettype wire

// [ssp_fifo.sv]
// byte fifo between frame builder and link transmitter
`timescale 1ns/10ps
`default_nettype none
module ssp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // depth must be a power of two: pointers wrap naturally
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic full;
   logic do_wr;
   logic do_rd;

   assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = (wr_r != rd_r);
   assign do_wr = in_valid && !full;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem_r[rd_r[AW-1:0]];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (do_wr) wr_r <= wr_r + 1'b1;
         if (do_rd) rd_r <= rd_r + 1'b1;
      end
   end

   // storage needs no reset, pointers guard it
   always_ff @(posedge ref_clk) begin
      if (do_wr) mem_r[wr_r[AW-1:0]] <= in_data;
   end
endmodule // ssp_fifo
`default_nettype wire

// [ssp_stream_port.sv]
// sensor data streaming port with automatic tuning and two link types
// Operation
// - stream_enable input: 0 streaming off, 1 streaming on.
// - link_select input: 0 one-wire link, 1 two-wire bus.
// - streaming on: device sends one frame after each charge cycle that ends while no frame is queuing, unasked.
// - two-wire: data on proximity pin, clock on touch pin.
// - two-wire control byte carries address 0x44 then the direction bit.
// - tuning runs at start-up and whenever counts leave the allowed range.
// - tuning flagged in streamed status; no proximity or touch events meanwhile.
// - tuning steps coarse multiplier and fine compensation toward the target count.
// - in normal running only a large count shift restarts tuning.
// - target count 1024 by default, 512 when selected.
`timescale 1ns/10ps
`default_nettype none
module ssp_stream_port
   import ssp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic stream_enable,
   input wire logic link_select,
   input wire logic target_select,
   input wire ssp_meas_type meas,
   input wire logic prox_event,
   input wire logic touch_event,
   output ssp_tune_type tune,
   output logic tuning_active,
   output logic frame_dropped,
   output logic nack_seen,
   input wire logic proximity_output_pin_in,
   output logic proximity_output_pin_out,
   output logic proximity_output_pin_oe,
   input wire logic touch_output_pin_in,
   output logic touch_output_pin_out,
   output logic touch_output_pin_oe
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic sda_s1_r, sda_s2_r, scl_s1_r, scl_s2_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
      end else begin
         sda_s1_r <= proximity_output_pin_in;
         sda_s2_r <= sda_s1_r;
         scl_s1_r <= touch_output_pin_in;
         scl_s2_r <= scl_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // automatic tuning
   ssp_ati_state_type ati_r, ati_nxt;
   ssp_tune_type tune_r, tune_nxt, tune_up, tune_dn;
   logic [CNT_W-1:0] target, diff;
   logic near, far, count_low, comp_max, comp_min, mult_max, mult_min, step;
   logic prox_q, touch_q;

   assign target = target_select ? TARGET_ALT : TARGET_DEF;
   assign diff = ssp_absdiff(meas.count, target);
   assign near = diff <= (target >> TOL_SHIFT);
   // wide margin so ordinary drift never disturbs detection
   assign far = diff > (target >> RANGE_SHIFT);
   assign count_low = meas.count < target;
   assign comp_max = &tune_r.comp;
   assign comp_min = ~|tune_r.comp;
   assign mult_max = &tune_r.mult;
   assign mult_min = ~|tune_r.mult;
   // fine step first, coarse step when fine runs out; saturates at the ends
   assign tune_up = comp_max ? (mult_max ? tune_r : {tune_r.mult + 1'b1, {COMP_W{1'b0}}})
                             : {tune_r.mult, tune_r.comp + 1'b1};
   assign tune_dn = comp_min ? (mult_min ? tune_r : {tune_r.mult - 1'b1, {COMP_W{1'b1}}})
                             : {tune_r.mult, tune_r.comp - 1'b1};
   assign step = (ati_r == ATI_TUNE) && meas.done && !near;
   assign tune_nxt = !step ? tune_r : (count_low ? tune_up : tune_dn);
   assign ati_nxt = !meas.done ? ati_r :
                    (ati_r == ATI_RUN) ? (far ? ATI_TUNE : ATI_RUN) :
                    (near ? ATI_RUN : ATI_TUNE);
   assign prox_q = prox_event && (ati_r == ATI_RUN);
   assign touch_q = touch_event && (ati_r == ATI_RUN);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ati_r <= ATI_TUNE;
         tune_r <= {MULT_RST, COMP_RST};
      end else begin
         ati_r <= ati_nxt;
         tune_r <= tune_nxt;
      end
   end
   assign tune = tune_r;
   assign tuning_active = (ati_r == ATI_TUNE);

   ////////////////////////////////////////////////////////////////////////
   // frame builder
   logic busy_r, drop_r;
   logic [1:0] idx_r;
   logic [8*FRAME_BYTES-1:0] snap_r, snap;
   logic take, push, in_ready, out_valid, pop;
   ssp_byte_type push_byte, head;

   assign take = meas.done && stream_enable && !busy_r;
   assign push = busy_r && in_ready;
   assign snap = {tune_r.mult, 1'b0, touch_q, prox_q, tuning_active,
                  meas.count, {(8 - COMP_W){1'b0}}, tune_r.comp};
   assign push_byte = {idx_r == 2'(FRAME_BYTES - 1), snap_r[8*FRAME_BYTES-1 -: 8]};

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
         idx_r <= 2'h0;
         snap_r <= '0;
         drop_r <= 1'b0;
      end else begin
         busy_r <= take || (busy_r && !(push && push_byte.last));
         idx_r <= take ? 2'h0 : (push ? idx_r + 2'h1 : idx_r);
         snap_r <= take ? snap : (push ? {snap_r[8*FRAME_BYTES-9:0], 8'h00} : snap_r);
         // a charge cycle that ends while the previous frame is still queuing is lost
         drop_r <= meas.done && stream_enable && busy_r;
      end
   end
   assign frame_dropped = drop_r;

   ssp_fifo #(.WIDTH($bits(ssp_byte_type)), .DEPTH(DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .in_valid(busy_r),
      .in_ready(in_ready),
      .in_data(push_byte),
      .out_valid(out_valid),
      .out_ready(pop),
      .out_data(head)
   );

   ////////////////////////////////////////////////////////////////////////
   // link transmitter, four quarter phases per bit
   ssp_tx_state_type tx_r, tx_nxt;
   logic [1:0] ph_r;
   logic [QCNT_W-1:0] qcnt_r;
   logic [9:0] sh_r;
   logic [3:0] bits_r;
   logic mode_r, last_r, flush_r, ack_r, nack_r;
   logic i2c, start, tick_raw, tick, stretch, starve, ph_end, need_byte;
   logic scl_lvl, sda_lvl, ow_lvl, ev_mode;
   logic prox_out_nxt, prox_oe_nxt, touch_out_nxt, touch_oe_nxt;
   logic prox_out_r, prox_oe_r, touch_out_r, touch_oe_r;

   assign i2c = (tx_r == TX_IDLE) ? link_select : mode_r;
   assign start = (tx_r == TX_IDLE) && out_valid && stream_enable;
   assign tick_raw = qcnt_r == QCNT_W'(QTR_CYC - 1);
   // the receiver may hold the clock low; wait for it before the high phase ends
   assign stretch = i2c && (ph_r == 2'h1) && !scl_s2_r && (tx_r != TX_IDLE) && (tx_r != TX_FLUSH);
   assign need_byte = (tx_r == TX_ACK) && (ph_r == 2'h3) && !ack_r && !last_r;
   assign starve = need_byte && !out_valid;
   assign tick = tick_raw && !stretch && !starve;
   assign ph_end = tick && (ph_r == 2'h3);
   assign pop = (start && !link_select) || (need_byte && ph_end) || ((tx_r == TX_FLUSH) && out_valid);

   always_comb begin
      tx_nxt = tx_r;
      case (tx_r)
         TX_IDLE: if (start) tx_nxt = link_select ? TX_START : TX_BITS;
         TX_START: if (ph_end) tx_nxt = TX_BITS;
         TX_BITS: if (ph_end && bits_r == 4'h1) tx_nxt = mode_r ? TX_ACK : TX_IDLE;
         TX_ACK: if (ph_end) tx_nxt = (ack_r || last_r) ? TX_STOP : TX_BITS;
         TX_STOP: if (ph_end) tx_nxt = flush_r ? TX_FLUSH : TX_IDLE;
         TX_FLUSH: if (out_valid && head.last) tx_nxt = TX_IDLE;
         default: tx_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_r <= TX_IDLE;
         ph_r <= 2'h0;
         qcnt_r <= '0;
         mode_r <= 1'b0;
      end else begin
         tx_r <= tx_nxt;
         ph_r <= (tx_r == TX_IDLE) ? 2'h0 : (tick ? ph_r + 2'h1 : ph_r);
         qcnt_r <= (tx_r == TX_IDLE || tick) ? '0 : (tick_raw ? qcnt_r : qcnt_r + 1'b1);
         if (start) mode_r <= link_select;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_r <= 10'h3FF;
         bits_r <= 4'h0;
         last_r <= 1'b0;
         flush_r <= 1'b0;
         ack_r <= 1'b0;
         nack_r <= 1'b0;
      end else begin
         if (start) begin
            sh_r <= link_select ? {DEV_ADDR, WR_BIT, 2'b11} : {1'b0, head.data, 1'b1};
            bits_r <= link_select ? I2C_BITS : OW_BITS;
            last_r <= !link_select && head.last;
         end else if (tx_r == TX_BITS && ph_end) begin
            sh_r <= {sh_r[8:0], 1'b1};
            bits_r <= bits_r - 4'h1;
         end else if (need_byte && ph_end) begin
            sh_r <= {head.data, 2'b11};
            bits_r <= I2C_BITS;
            last_r <= head.last;
         end
         if (tx_r == TX_ACK && tick && ph_r == 2'h2) ack_r <= sda_s2_r;
         if (tx_r == TX_IDLE) flush_r <= 1'b0;
         else if (tx_r == TX_ACK && ph_end && ack_r && !last_r) flush_r <= 1'b1;
         nack_r <= (tx_r == TX_ACK) && ph_end && ack_r;
      end
   end
   assign nack_seen = nack_r;

   ////////////////////////////////////////////////////////////////////////
   // pin drive; two-wire lines are open drain, data changes only with clock low except at start and stop
   assign scl_lvl = (tx_r == TX_START) ? (ph_r != 2'h3) :
                    (tx_r == TX_BITS || tx_r == TX_ACK) ? (ph_r == 2'h1 || ph_r == 2'h2) :
                    (tx_r == TX_STOP) ? (ph_r != 2'h0) : 1'b1;
   assign sda_lvl = (tx_r == TX_START) ? (ph_r < 2'h2) :
                    (tx_r == TX_BITS) ? sh_r[9] :
                    (tx_r == TX_STOP) ? (ph_r >= 2'h2) : 1'b1;
   assign ow_lvl = (tx_r == TX_BITS) ? sh_r[9] : 1'b1;
   assign ev_mode = !stream_enable && (tx_r == TX_IDLE);
   assign prox_out_nxt = ev_mode ? prox_q : (i2c ? 1'b0 : ow_lvl);
   assign prox_oe_nxt = ev_mode || !i2c || !sda_lvl;
   assign touch_out_nxt = (ev_mode || !i2c) ? touch_q : 1'b0;
   assign touch_oe_nxt = ev_mode || !i2c || !scl_lvl;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prox_out_r <= 1'b0;
         prox_oe_r <= 1'b0;
         touch_out_r <= 1'b0;
         touch_oe_r <= 1'b0;
      end else begin
         prox_out_r <= prox_out_nxt;
         prox_oe_r <= prox_oe_nxt;
         touch_out_r <= touch_out_nxt;
         touch_oe_r <= touch_oe_nxt;
      end
   end
   assign proximity_output_pin_out = prox_out_r;
   assign proximity_output_pin_oe = prox_oe_r;
   assign touch_output_pin_out = touch_out_r;
   assign touch_output_pin_oe = touch_oe_r;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   AST_TUNE_AT_START: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(rst_b) |-> tuning_active) else $error("tuning not active after reset");
   AST_RETUNE_FAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (ati_r == ATI_RUN && meas.done && far) |=> tuning_active) else $error("far count did not retune");
   AST_NO_SMALL_RETUNE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (ati_r == ATI_RUN && meas.done && !far) |=> !tuning_active) else $error("small shift retuned");
   AST_TARGET_HIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (ati_r == ATI_TUNE && meas.done && meas.count == (target_select ? TARGET_ALT : TARGET_DEF))
      |=> !tuning_active) else $error("tuning missed its target");
   AST_FINE_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (step && count_low && !comp_max) |=> (tune.comp == $past(tune.comp) + 1'b1)
      && $stable(tune.mult)) else $error("fine step wrong");
   AST_FRAME_TAKEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
      take |=> busy_r && snap_r[15:8] == $past(meas.count[7:0])) else $error("frame not captured");
   AST_NO_START_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!stream_enable && tx_r == TX_IDLE) |=> tx_r == TX_IDLE) else $error("traffic while disabled");
   AST_ADDR_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (start && link_select) |=> tx_r == TX_START && sh_r[9:2] == {DEV_ADDR, WR_BIT})
      else $error("wrong control byte");
   AST_ONE_WIRE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (start && !link_select) |=> tx_r == TX_BITS && !sh_r[9]) else $error("one-wire start bit wrong");
   AST_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (tx_r != TX_IDLE && mode_r) |=> !proximity_output_pin_out && !touch_output_pin_out)
      else $error("two-wire pin driven high");
   AST_EVENTS_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (ev_mode && tuning_active) |=> proximity_output_pin_oe && touch_output_pin_oe
      && !proximity_output_pin_out && !touch_output_pin_out) else $error("event during tuning");
endmodule // ssp_stream_port
`default_nettype wire

// [ssp_mcu_model.sv]
// receiving microcontroller model on the two-wire streaming bus
`timescale 1ns/10ps
`default_nettype none
module ssp_mcu_model (
   input wire logic sda,
   input wire logic scl,
   input wire logic nack_en,
   input wire logic stretch_en,
   output logic sda_low,
   output logic scl_low
);
   logic active, first;
   logic [3:0] nbit;
   logic [7:0] shreg;
   int starts, stops;
   logic [7:0] got[$];
   initial begin
      sda_low = 1'b0;
      scl_low = 1'b0;
      active = 1'b0;
      first = 1'b0;
      nbit = 4'h0;
      shreg = 8'h00;
      starts = 0;
      stops = 0;
   end
   // data on proximity pin, clock on touch pin
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         active = 1'b1;
         first = 1'b1;
         nbit = 4'h0;
         starts++;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1 && active) begin
         active = 1'b0;
         stops++;
      end
   end
   always @(posedge scl) begin
      if (active && nbit < 4'h8) begin
         shreg = {shreg[6:0], sda};
      end
      if (active) begin
         nbit++;
      end
   end
   // ack only our own address in the control byte
   always @(negedge scl) begin
      if (active && nbit == 4'h8) begin
         got.push_back(shreg);
         sda_low = !nack_en && (!first || shreg[7:1] == 7'h44);
         first = 1'b0;
      end else if (active && nbit == 4'h9) begin
         sda_low = 1'b0;
         nbit = 4'h0;
      end
   end
   // slow receiver: hold the clock low a while after each fall
   always @(negedge scl) begin
      if (active && stretch_en) begin
         scl_low = 1'b1;
         #200;
         scl_low = 1'b0;
      end
   end
endmodule // ssp_mcu_model
`default_nettype wire

// [ssp_stream_port_bench.sv]
// self-checking bench for the sensor streaming port
`timescale 1ns/10ps
`default_nettype none
module ssp_stream_port_bench;
   import ssp_pkg::*;
   logic ref_clk, rst_b, stream_enable, link_select, target_select, prox_event, touch_event;
   ssp_meas_type meas;
   ssp_tune_type tune;
   logic tuning_active, frame_dropped, nack_seen, p_out, p_oe, t_out, t_oe;
   logic nack_en, stretch_en, m_sda_low, m_scl_low;
   wire logic sda;
   wire logic scl;
   int err_count, checked;
   // pull-ups on both wires; push-pull high wins only when nobody pulls low
   assign sda = !((p_oe & !p_out) | m_sda_low);
   assign scl = !((t_oe & !t_out) | m_scl_low);
   ssp_stream_port #(.DEPTH(FIFO_DEPTH)) u_ssp_stream_port (.ref_clk(ref_clk), .rst_b(rst_b),
      .stream_enable(stream_enable), .link_select(link_select), .target_select(target_select),
      .meas(meas), .prox_event(prox_event), .touch_event(touch_event), .tune(tune),
      .tuning_active(tuning_active), .frame_dropped(frame_dropped), .nack_seen(nack_seen),
      .proximity_output_pin_in(sda), .proximity_output_pin_out(p_out), .proximity_output_pin_oe(p_oe),
      .touch_output_pin_in(scl), .touch_output_pin_out(t_out), .touch_output_pin_oe(t_oe));
   ssp_mcu_model u_ssp_mcu_model (.sda(sda), .scl(scl), .nack_en(nack_en), .stretch_en(stretch_en),
      .sda_low(m_sda_low), .scl_low(m_scl_low));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic give_up(input string msg);
      err_count++;
      $display("wrong value at %0t: %s timed out", $time, msg);
      print_verdict();
   endtask
   task automatic done_pulse(input logic [15:0] cnt, input int len);
      @(posedge ref_clk);
      meas <= '{done: 1'b1, count: cnt};
      repeat (len) @(posedge ref_clk);
      meas.done <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_stops(input int n);
      int k;
      k = 0;
      while (u_ssp_mcu_model.stops < n) begin
         @(posedge ref_clk);
         k++;
         if (k > 6000) give_up("stop");
      end
   endtask
   // one-wire byte: poll for the start bit, then sample mid-bit
   task automatic rx_ow(output logic [7:0] b);
      int k;
      k = 0;
      while (sda !== 1'b0) begin
         #4;
         k++;
         if (k > 3000) give_up("one-wire start");
      end
      #64;
      for (int i = 0; i < 8; i++) begin
         #128;
         b = {b[6:0], sda};
      end
      #128;
      check(sda, 1'b1, "stop bit");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      @(posedge ref_clk);
      prox_event <= 1'b1;
      touch_event <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      check(tuning_active, 1'b1, "tuning after reset");
      check(tune, {MULT_RST, COMP_RST}, "tune at reset");
      check({p_oe, t_oe, sda, scl}, 4'hC, "events masked while tuning");
   endtask
   task automatic t_tune();
      done_pulse(16'h0000, 1);
      check(tune, {4'h0, 6'h21}, "comp up");
      done_pulse(16'h0800, 1);
      check(tune, {4'h0, 6'h20}, "comp down");
      done_pulse(16'h0410, 1);
      check(tuning_active, 1'b0, "locked near target");
      check({sda, scl}, 2'h3, "events pass in run");
      done_pulse(16'h04C8, 1);
      check(tuning_active, 1'b0, "small shift kept");
      done_pulse(16'h0546, 1);
      check(tuning_active, 1'b1, "large shift retunes");
      @(posedge ref_clk);
      target_select <= 1'b1;
      done_pulse(16'h0200, 1);
      check(tuning_active, 1'b0, "locks on lower target");
      check(tune, {4'h0, 6'h20}, "comp held");
   endtask
   task automatic t_i2c(input logic slow);
      int s0;
      logic [7:0] exp [5];
      exp = '{8'h88, 8'h02, 8'h02, 8'h0A, 8'h20};
      @(posedge ref_clk);
      touch_event <= 1'b0;
      stretch_en <= slow;
      link_select <= 1'b1;
      stream_enable <= 1'b1;
      repeat (4) @(posedge ref_clk);
      u_ssp_mcu_model.got.delete();
      s0 = u_ssp_mcu_model.stops;
      done_pulse(16'h020A, 1);
      wait_stops(s0 + 1);
      check(u_ssp_mcu_model.got.size(), 5, "bytes per frame");
      check(u_ssp_mcu_model.got[0], exp[0], "control byte");
      for (int i = 1; i < 5; i++) begin
         check(u_ssp_mcu_model.got[i], exp[i], "frame byte");
      end
   endtask
   task automatic t_onewire();
      logic [7:0] b;
      @(posedge ref_clk);
      link_select <= 1'b0;
      repeat (4) @(posedge ref_clk);
      done_pulse(16'h0012, 1);
      for (int i = 0; i < 4; i++) begin
         rx_ow(b);
      end
      check(tuning_active, 1'b1, "retune on range exit");
      done_pulse(16'h0012, 1);
      rx_ow(b);
      check(b, 8'h01, "status while tuning");
      rx_ow(b);
      check(b, 8'h00, "count high");
      rx_ow(b);
      check(b, 8'h12, "count low");
      rx_ow(b);
      check(b, 8'h20, "compensation byte");
   endtask
   task automatic t_nack();
      int s0, k;
      logic drop, nck;
      k = 0;
      @(posedge ref_clk);
      link_select <= 1'b1;
      nack_en <= 1'b1;
      stretch_en <= 1'b0;
      repeat (4) @(posedge ref_clk);
      u_ssp_mcu_model.got.delete();
      s0 = u_ssp_mcu_model.stops;
      // drop flag stands one cycle only; look right after the second done
      @(posedge ref_clk);
      meas <= '{done: 1'b1, count: 16'h0012};
      repeat (2) @(posedge ref_clk);
      meas.done <= 1'b0;
      #1;
      drop = frame_dropped;
      nck = 1'b0;
      while (u_ssp_mcu_model.stops == s0) begin
         @(posedge ref_clk);
         #1;
         drop |= frame_dropped;
         nck |= nack_seen;
         k++;
         if (k > 6000) give_up("nack stop");
      end
      check(drop, 1'b1, "back-to-back done refused");
      check(nck, 1'b1, "nack reported");
      check(u_ssp_mcu_model.got.size(), 1, "frame cut after nack");
      @(posedge ref_clk);
      nack_en <= 1'b0;
      u_ssp_mcu_model.got.delete();
      done_pulse(16'h0034, 1);
      wait_stops(s0 + 2);
      check(u_ssp_mcu_model.got.size(), 5, "no stale bytes");
      check(u_ssp_mcu_model.got[3], 8'h34, "fresh count");
   endtask
   task automatic t_off();
      int s0;
      @(posedge ref_clk);
      stream_enable <= 1'b0;
      touch_event <= 1'b1;
      repeat (4) @(posedge ref_clk);
      s0 = u_ssp_mcu_model.starts;
      done_pulse(16'h0012, 1);
      repeat (1500) @(posedge ref_clk);
      #1;
      check(u_ssp_mcu_model.starts - s0, 0, "silent when off");
      check({p_oe, t_oe, sda, scl}, 4'hC, "event pins masked");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      rst_b = 1'b0;
      stream_enable = 1'b0;
      link_select = 1'b0;
      target_select = 1'b0;
      prox_event = 1'b0;
      touch_event = 1'b0;
      meas = '0;
      nack_en = 1'b0;
      stretch_en = 1'b0;
      err_count = 0;
      checked = 0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_tune();
      t_i2c(1'b0);
      t_i2c(1'b1);
      t_onewire();
      t_nack();
      t_off();
      print_verdict();
   end
endmodule // ssp_stream_port_bench
`default_nettype wire
